// *** usart_frame_tx_rx.sv ***
// USART top: AHB-Lite registers, transmitter, receive buffer and interrupt requests
`default_nettype none
`include "usart_map.svh"
module usart_frame_tx_rx (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Serial pins and their general-purpose fallback
    input wire logic rxPin,
    input wire logic gpioTxOut,
    output logic txPinOut,
    output logic txOwned,
    output logic rxOwned,
    // Interrupt requests to the core
    input wire logic globalIrqEn,
    input wire logic txDoneIrqAck,
    output logic txEmptyIrq,
    output logic txDoneIrq,
    output logic rxDoneIrq
);
    import usart_pkg::*;

    // Software state
    frame_cfg_s cfg;
    logic txEnReq;
    logic rx_enable;
    logic rxIrqEn;
    logic txcIrqEn;
    logic txeIrqEn;
    logic txNinth;
    logic [15:0] baudDiv;

    // Transmit state
    logic [8:0] txBuf;
    logic txBufFull;
    logic txComplete;
    tx_state_e txState;
    logic [8:0] txShift;
    logic [3:0] txCnt;
    logic [3:0] txBit;
    logic txStop2;
    logic txPar;

    // Receive buffer: one readable entry plus the frame parked in the shifter
    rx_frame_s rxBuf;
    logic rxBufOvr;
    logic rxBufValid;
    rx_frame_s rxHold;
    logic rxHoldValid;
    logic ovrPending;

    // Bus phase tracking
    logic wrPend;
    logic [7:0] wrAddr;
    logic apValid;
    logic rdData;
    logic writeData;
    logic writeA;
    logic writeB;
    logic writeCfg;
    logic writeBaud;
    logic [31:0] next_hrdata;

    // Helper signals
    logic tick;
    logic [3:0] nBits;
    logic txFrameEnd;
    logic txLoad;
    logic txSerial;
    logic rxStart;
    logic rxDone;
    rx_frame_s rxFrame;
    logic pop;
    logic bufFree;

    assign nBits = data_bits(cfg.charSize);
    assign apValid = hsel && htrans[1] && hready;
    assign rdData = apValid && !hwrite && haddr[31:8] == 24'h000000 && haddr[7:0] == `OFS_DATA;
    assign pop = rdData && rxBufValid;
    assign writeData = wrPend && wrAddr == `OFS_DATA;
    assign writeA = wrPend && wrAddr == `OFS_STATUS_A;
    assign writeB = wrPend && wrAddr == `OFS_CTRL_B;
    assign writeCfg = wrPend && wrAddr == `OFS_FRAME_CFG;
    assign writeBaud = wrPend && wrAddr == `OFS_BAUD_DIV;

    usart_baud_tick u_baud (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .divisor(baudDiv),
        .reload(writeBaud),
        .tick(tick)
    );

    usart_rx_shift u_rx (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .tick(tick),
        .enable(rx_enable),
        .cfg(cfg),
        .rxIn(rxPin),
        .startSeen(rxStart),
        .frameDone(rxDone),
        .frame(rxFrame)
    );

    // Read mux; reserved bits and unmapped offsets read as zero
    always_comb begin
        next_hrdata = 32'h0000_0000;
        case (haddr[7:0])
            `OFS_DATA: next_hrdata[8:0] = rxBufValid ? rxBuf.data : 9'h000;
            `OFS_STATUS_A: begin
                next_hrdata[`A_RX_COMPLETE] = rxBufValid;
                next_hrdata[`A_TX_COMPLETE] = txComplete;
                next_hrdata[`A_TX_EMPTY] = !txBufFull;
                next_hrdata[`A_FRAMING_ERR] = rxBufValid && !rxBuf.stopOk;
                next_hrdata[`A_OVERRUN_ERR] = rxBufValid && rxBufOvr;
                next_hrdata[`A_PARITY_ERR] = rxBufValid && rxBuf.parityBad &&
                    cfg.parityMode[1];
            end
            `OFS_CTRL_B: begin
                next_hrdata[`B_RX_IRQ_EN] = rxIrqEn;
                next_hrdata[`B_TXC_IRQ_EN] = txcIrqEn;
                next_hrdata[`B_TXE_IRQ_EN] = txeIrqEn;
                next_hrdata[`B_RX_ENABLE] = rx_enable;
                next_hrdata[`B_TX_ENABLE] = txEnReq;
                next_hrdata[`B_RX_NINTH] = rxBufValid && rxBuf.data[8];
                next_hrdata[`B_TX_NINTH] = txNinth;
            end
            `OFS_FRAME_CFG: next_hrdata[5:0] = cfg;
            `OFS_BAUD_DIV: next_hrdata[15:0] = baudDiv;
            default: next_hrdata = 32'h0000_0000;
        endcase
    end

    // Zero-wait slave: reads sampled at the address phase, writes done in the data phase
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h0000_0000;
            wrPend <= 1'b0;
            wrAddr <= 8'h00;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wrPend <= apValid && hwrite && haddr[31:8] == 24'h000000;
            wrAddr <= haddr[7:0];
            if (apValid && !hwrite) begin
                hrdata <= haddr[31:8] == 24'h000000 ? next_hrdata : 32'h0000_0000;
            end
        end
    end

    // Control registers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cfg <= '0;
            txEnReq <= 1'b0;
            rx_enable <= 1'b0;
            rxIrqEn <= 1'b0;
            txcIrqEn <= 1'b0;
            txeIrqEn <= 1'b0;
            txNinth <= 1'b0;
            baudDiv <= `BAUD_DIV_RST;
        end else begin
            if (writeB) begin
                rxIrqEn <= hwdata[`B_RX_IRQ_EN];
                txcIrqEn <= hwdata[`B_TXC_IRQ_EN];
                txeIrqEn <= hwdata[`B_TXE_IRQ_EN];
                rx_enable <= hwdata[`B_RX_ENABLE];
                txEnReq <= hwdata[`B_TX_ENABLE];
                txNinth <= hwdata[`B_TX_NINTH];
            end
            if (writeCfg) begin
                cfg <= hwdata[5:0];
            end
            if (writeBaud) begin
                baudDiv <= hwdata[15:0];
            end
        end
    end

    // Pin ownership; a cleared transmit enable waits for shifter and buffer to drain, a cleared receive enable releases at once
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            txOwned <= 1'b0;
            rxOwned <= 1'b0;
        end else begin
            txOwned <= txEnReq || (txOwned && (txState != TX_IDLE || txBufFull));
            rxOwned <= rx_enable;
        end
    end

    assign txFrameEnd = tick && txCnt == `SAMPLE_LAST && txState == TX_STOP &&
        (!cfg.stopTwo || txStop2);
    assign txLoad = txOwned && txBufFull && (txState == TX_IDLE || txFrameEnd);

    // Transmit buffer; ninth bit is taken from the control bit at the data write
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            txBuf <= 9'h000;
            txBufFull <= 1'b0;
        end else if (writeData) begin
            txBuf <= {txNinth, hwdata[7:0]};
            txBufFull <= 1'b1;
        end else if (txLoad) begin
            txBufFull <= 1'b0;
        end
    end

    // Transmit sequencer, sixteen sample ticks per bit
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            txState <= TX_IDLE;
            txShift <= 9'h000;
            txCnt <= 4'h0;
            txBit <= 4'h0;
            txStop2 <= 1'b0;
            txPar <= 1'b0;
        end else if (txLoad) begin
            // Reload straight from the last stop gives back-to-back frames
            txState <= TX_START;
            txShift <= txBuf;
            txCnt <= 4'h0;
            txBit <= 4'h0;
            txStop2 <= 1'b0;
            txPar <= frame_parity(txBuf, nBits, cfg.parityMode[0]);
        end else if (txState != TX_IDLE && tick) begin
            txCnt <= txCnt + 4'h1;
            if (txCnt == `SAMPLE_LAST) begin
                case (txState)
                    TX_START: txState <= TX_DATA;
                    TX_DATA: begin
                        txBit <= txBit + 4'h1;
                        if (txBit == nBits - 4'h1) begin
                            txState <= cfg.parityMode[1] ? TX_PARITY : TX_STOP;
                        end
                    end
                    TX_PARITY: txState <= TX_STOP;
                    TX_STOP: begin
                        if (cfg.stopTwo && !txStop2) begin
                            txStop2 <= 1'b1;
                        end else begin
                            txState <= TX_IDLE;
                        end
                    end
                    default: txState <= TX_IDLE;
                endcase
            end
        end
    end

    // Line level per state; bits above the data count are never sent
    always_comb begin
        case (txState)
            TX_START: txSerial = 1'b0;
            TX_DATA: txSerial = txShift[txBit];
            TX_PARITY: txSerial = txPar;
            TX_STOP: txSerial = 1'b1;
            default: txSerial = 1'b1;
        endcase
    end

    // Registered pin mux keeps the output glitch free
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            txPinOut <= 1'b1;
        end else begin
            txPinOut <= txOwned ? txSerial : gpioTxOut;
        end
    end

    // Transmit complete; a new completion wins over a clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            txComplete <= 1'b0;
        end else if (txFrameEnd && !txBufFull) begin
            txComplete <= 1'b1;
        end else if (txDoneIrqAck || (writeA && hwdata[`A_TX_COMPLETE])) begin
            txComplete <= 1'b0;
        end
    end

    assign bufFree = !rxBufValid || (pop && !rxHoldValid);

    // Receive buffer; errors and ninth bit move with their frame
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !rx_enable) begin
            rxBuf <= '0;
            rxBufOvr <= 1'b0;
            rxBufValid <= 1'b0;
            rxHold <= '0;
            rxHoldValid <= 1'b0;
        end else if (rxDone && bufFree) begin
            rxBuf <= rxFrame;
            rxBufOvr <= ovrPending;
            rxBufValid <= 1'b1;
        end else if (pop && rxHoldValid) begin
            rxBuf <= rxHold;
            rxBufOvr <= ovrPending;
            rxHold <= rxFrame;
            rxHoldValid <= rxDone;
        end else if (rxDone) begin
            rxHold <= rxFrame;
            rxHoldValid <= 1'b1;
        end else if (pop) begin
            rxBufValid <= 1'b0;
        end
    end

    // Overrun pending; cleared by the next successful move into the buffer
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !rx_enable) begin
            ovrPending <= 1'b0;
        end else if (rxStart && rxBufValid && rxHoldValid && !pop) begin
            ovrPending <= 1'b1;
        end else if ((rxDone && bufFree) || (pop && rxHoldValid)) begin
            ovrPending <= 1'b0;
        end
    end

    // Level interrupt requests; the error flags take no part
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            txEmptyIrq <= 1'b0;
            txDoneIrq <= 1'b0;
            rxDoneIrq <= 1'b0;
        end else begin
            txEmptyIrq <= globalIrqEn && txeIrqEn && !txBufFull;
            txDoneIrq <= globalIrqEn && txcIrqEn && txComplete;
            rxDoneIrq <= globalIrqEn && rxIrqEn && rxBufValid;
        end
    end

    sequence s_start_bit;
        txState == TX_START && txOwned;
    endsequence

    sequence s_last_stop;
        txFrameEnd && !txBufFull && !writeData;
    endsequence

    a_start_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_start_bit |=> txPinOut == 1'b0)
        else $error("start bit not driven low");

    a_stop_high: assert property (@(posedge sys_clk) disable iff (!rst_n)
        txState == TX_STOP && txOwned |=> txPinOut == 1'b1)
        else $error("stop bit not driven high");

    a_write_fills: assert property (@(posedge sys_clk) disable iff (!rst_n)
        writeData |=> txBufFull)
        else $error("data write did not clear buffer empty");

    // A write landing on the load edge refills the buffer at once
    a_load_starts: assert property (@(posedge sys_clk) disable iff (!rst_n)
        txLoad |=> txState == TX_START && (!txBufFull || $past(writeData)))
        else $error("buffer did not move into shifter");

    a_done_sets: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_last_stop |=> txComplete ##1 txDoneIrq || !($past(txcIrqEn) && $past(globalIrqEn)))
        else $error("transmit complete not raised");

    a_empty_irq: assert property (@(posedge sys_clk) disable iff (!rst_n)
        globalIrqEn && txeIrqEn && !txBufFull |=> txEmptyIrq)
        else $error("empty interrupt missing");

    a_tx_hold_pin: assert property (@(posedge sys_clk) disable iff (!rst_n)
        txOwned && (txState != TX_IDLE || txBufFull) |=> txOwned)
        else $error("pin released before transmitter drained");

    a_rx_flush: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !rx_enable |=> !rxBufValid ##1 !rxDoneIrq)
        else $error("receive buffer not flushed on disable");

    a_rx_irq: assert property (@(posedge sys_clk) disable iff (!rst_n)
        globalIrqEn && rxIrqEn && rxBufValid |=> rxDoneIrq)
        else $error("receive interrupt missing");

    a_frame_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
        txState == TX_DATA |-> txBit < nBits)
        else $error("data bit index beyond frame size");
endmodule : usart_frame_tx_rx
`default_nettype wire

// *** usart_map.svh ***
// Register offsets, field positions, reset values and timing counts of the USART
//
// What this block does
// - One start, 5-9 data, parity, 1-2 stops
// - Data LSB first, then parity, then stops
// - Next frame back to back or idle high
// - Start bit low, stop bits high
// - Transmitter and receiver share one frame setup
// - Parity is data XOR, inverted for odd
// - Parity inserted after last data bit
// - Transmit enable takes the output pin
// - Buffer loads shifter when idle or frame ends
// - Buffer empty flag; data write clears it
// - Empty interrupt held while buffer empty
// - Done flag when frame out, buffer empty
// - Done interrupt; cleared by entry or one
// - Transmit disable waits until all sent
// - Receive enable takes the input pin
// - Shift in bits; first stop buffers frame
// - Ninth bit and errors travel with frame
// - Receive flag shows unread data; disable flushes
// - Receive interrupt held until data read
// - Error flags stored, never interrupt
// - Framing error from first stop only
// - Overrun on start with buffer and shifter full
// - Parity error per frame, zero when disabled
`ifndef USART_MAP_SVH
`define USART_MAP_SVH

// Byte offsets on the register bus
`define OFS_DATA 8'h00
`define OFS_STATUS_A 8'h04
`define OFS_CTRL_B 8'h08
`define OFS_FRAME_CFG 8'h0C
`define OFS_BAUD_DIV 8'h10

// ctrl_status_a fields
`define A_RX_COMPLETE 7
`define A_TX_COMPLETE 6
`define A_TX_EMPTY 5
`define A_FRAMING_ERR 4
`define A_OVERRUN_ERR 3
`define A_PARITY_ERR 2

// ctrl_status_b fields
`define B_RX_IRQ_EN 7
`define B_TXC_IRQ_EN 6
`define B_TXE_IRQ_EN 5
`define B_RX_ENABLE 4
`define B_TX_ENABLE 3
`define B_RX_NINTH 1
`define B_TX_NINTH 0

// Reset values and timing
`define BAUD_DIV_RST 16'h0000
`define SAMPLE_LAST 4'hF
`define SAMPLE_MID 4'h7

`endif

// *** usart_pkg.sv ***
// Types and frame helpers shared by the USART modules
`default_nettype none
package usart_pkg;
    typedef struct packed {
        logic [1:0] parityMode;
        logic stopTwo;
        logic [2:0] charSize;
    } frame_cfg_s;

    typedef struct packed {
        logic [8:0] data;
        logic stopOk;
        logic parityBad;
    } rx_frame_s;

    typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} tx_state_e;
    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_e;

    // Data bit count from char_size_field; reserved codes fall back to eight
    function automatic logic [3:0] data_bits(input logic [2:0] cs);
        case (cs)
            3'h0: data_bits = 4'h5;
            3'h1: data_bits = 4'h6;
            3'h2: data_bits = 4'h7;
            3'h7: data_bits = 4'h9;
            default: data_bits = 4'h8;
        endcase
    endfunction : data_bits

    // XOR over the used data bits, inverted for odd parity
    function automatic logic frame_parity(input logic [8:0] d, input logic [3:0] n,
                                          input logic odd);
        logic p;
        p = odd;
        for (int i = 0; i < 9; i++) begin
            if (i < int'(n)) begin
                p = p ^ d[i];
            end
        end
        frame_parity = p;
    endfunction : frame_parity
endpackage : usart_pkg
`default_nettype wire

// *** usart_baud_tick.sv ***
// Baud divider producing a one-cycle sample enable, sixteen per bit
`default_nettype none
module usart_baud_tick (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Divisor and restart on write
    input wire logic [15:0] divisor,
    input wire logic reload,
    // Sample enable
    output logic tick
);
    logic [15:0] count;

    // Down counter; a divisor write restarts it, but the first period after it still counts the divisor from before the write
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            count <= 16'h0000;
            tick <= 1'b0;
        end else if (reload || count == 16'h0000) begin
            count <= divisor;
            tick <= !reload;
        end else begin
            count <= count - 16'h0001;
            tick <= 1'b0;
        end
    end
endmodule : usart_baud_tick
`default_nettype wire

// *** usart_rx_shift.sv ***
// Receive shifter: start validation, mid-bit sampling, frame assembly
`default_nettype none
`include "usart_map.svh"
module usart_rx_shift (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Control
    input wire logic tick,
    input wire logic enable,
    input wire usart_pkg::frame_cfg_s cfg,
    // Serial input
    input wire logic rxIn,
    // Frame out
    output logic startSeen,
    output logic frameDone,
    output usart_pkg::rx_frame_s frame
);
    import usart_pkg::*;

    rx_state_e state;
    logic [3:0] cnt;
    logic [3:0] bitIdx;
    logic [8:0] data;
    logic parBit;
    logic [3:0] nBits;

    assign nBits = data_bits(cfg.charSize);

    // Bit sampler; a disable drops any frame in flight
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !enable) begin
            state <= RX_IDLE;
            cnt <= 4'h0;
            bitIdx <= 4'h0;
            data <= 9'h000;
            parBit <= 1'b0;
            startSeen <= 1'b0;
            frameDone <= 1'b0;
            frame <= '0;
        end else begin
            startSeen <= 1'b0;
            frameDone <= 1'b0;
            if (tick) begin
                cnt <= cnt + 4'h1;
                case (state)
                    RX_IDLE: begin
                        cnt <= 4'h0;
                        bitIdx <= 4'h0;
                        data <= 9'h000;
                        if (!rxIn) begin
                            state <= RX_START;
                        end
                    end
                    RX_START: begin
                        // Recheck at mid bit so a glitch is not taken as a start
                        if (cnt == `SAMPLE_MID) begin
                            cnt <= 4'h0;
                            state <= rxIn ? RX_IDLE : RX_DATA;
                            startSeen <= !rxIn;
                        end
                    end
                    RX_DATA: begin
                        if (cnt == `SAMPLE_LAST) begin
                            data[bitIdx] <= rxIn;
                            bitIdx <= bitIdx + 4'h1;
                            if (bitIdx == nBits - 4'h1) begin
                                state <= cfg.parityMode[1] ? RX_PARITY : RX_STOP;
                            end
                        end
                    end
                    RX_PARITY: begin
                        if (cnt == `SAMPLE_LAST) begin
                            parBit <= rxIn;
                            state <= RX_STOP;
                        end
                    end
                    RX_STOP: begin
                        // First stop closes the frame; a second one is not looked at
                        if (cnt == `SAMPLE_LAST) begin
                            state <= RX_IDLE;
                            frameDone <= 1'b1;
                            frame.data <= data;
                            frame.stopOk <= rxIn;
                            frame.parityBad <= cfg.parityMode[1] &&
                                (parBit != frame_parity(data, nBits, cfg.parityMode[0]));
                        end
                    end
                    default: state <= RX_IDLE;
                endcase
            end
        end
    end

    a_rx_done_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
        frameDone |-> state == RX_IDLE)
        else $error("receiver did not return to idle after first stop");
endmodule : usart_rx_shift
`default_nettype wire

// *** remote_node.sv ***
// Remote serial node: frame sender and mid-bit frame sampler
`default_nettype none
module remote_node (
    // Clock
    input wire logic sys_clk,
    // Serial lines
    input wire logic txLine,
    output logic rxLine
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [9:0] got;
    int frames = 0;
    initial rxLine = 1'b1; // Idle high between frames
    // Sample mid-bit, 16 cycles a bit at the fastest divisor
    always @(negedge txLine) begin
        repeat (8) @(posedge sys_clk);
        for (int i = 0; i < 10; i++) begin
            repeat (16) @(posedge sys_clk);
            got[i] = txLine; // LSB first, parity, stop
        end
        frames++;
    end
    // Whole frame only: start low, data, parity, stop high
    task automatic send(input logic [8:0] dp);
        logic [10:0] f;
        f = {1'b1, dp, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(posedge sys_clk);
            rxLine <= f[i];
            repeat (15) @(posedge sys_clk);
        end
    endtask : send
endmodule : remote_node
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench: bus tasks and frame round trips against a queue model
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_total++; \
    $display("wrong value at %0t: got %h exp %h", $time, a, e); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 0, rst_n = 0, hsel = 0, hwrite = 0, glbEn = 1;
    logic [31:0] haddr = 0, hwdata = 0, rd, r;
    logic [1:0] htrans = 0;
    logic hready, hresp, txPin, txOwn, rxLine, txeIrq, txdIrq, rxIrq, p;
    logic gpio = 1'b1, ack = 1'b0, rxOwn, n9;
    logic [15:0] seed = 16'h9432;
    logic [7:0] q[$];
    logic [7:0] b;
    int err_total = 0, n_tests = 0, cyc = 0;
    usart_frame_tx_rx dut (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(rd), .rxPin(rxLine), .gpioTxOut(gpio),
        .txPinOut(txPin), .txOwned(txOwn), .rxOwned(rxOwn), .globalIrqEn(glbEn),
        .txDoneIrqAck(ack), .txEmptyIrq(txeIrq), .txDoneIrq(txdIrq), .rxDoneIrq(rxIrq));
    remote_node rn (.sys_clk(sys_clk), .txLine(txPin), .rxLine(rxLine));
    initial forever #5 sys_clk = ~sys_clk;
    // Hang guard; a frame round trip is well under 500 cycles
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 6000) begin
            err_total++;
            finish_test();
        end
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    // One single transfer; request held until hready is seen high
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] x);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge sys_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge sys_clk); while (hready !== 1'b1);
        x = rd;
    endtask : bus
    task automatic finish_test();
        $display("checks %0d, errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test
    initial begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        bus(0, 8'h04, 0, r);
        `CHK(r[7:2], 6'h08)
        `CHK(txOwn, 1'b0)
        bus(0, 8'hFC, 0, r);
        `CHK(r, 32'h0)
        `CHK(hresp, 1'b0)
        bus(1, 8'h08, 32'hF8, r);
        // Even and odd parity, two stops on the fourth, then a 9-bit frame without parity
        for (int i = 0; i < 5; i++) begin
            seed = lfsr(seed);
            q.push_back(seed[7:0]);
            n9 = (i == 4) && seed[8];
            bus(1, 8'h08, {24'h0, 7'h7C, n9}, r);
            `CHK(txeIrq, 1'b1)
            bus(1, 8'h0C, (i == 4) ? 32'h7 : {26'h0, 1'b1, i[0], i == 3, 3'h3}, r);
            bus(1, 8'h00, {24'h0, seed[7:0]}, r);
            for (int k = 0; k < 400 && rn.frames == i; k++) @(posedge sys_clk);
            b = q.pop_front();
            p = (i == 4) ? n9 : ^b ^ i[0];
            `CHK(rn.got, {1'b1, p, b})
            `CHK(txOwn, 1'b1)
            `CHK(rxOwn, 1'b1)
            rn.send({p ^ (i == 2), b});
            bus(0, 8'h04, 0, r);
            `CHK(r[7:2], {5'h1C, i == 2})
            `CHK(rxIrq, 1'b1)
            `CHK(txdIrq, 1'b1)
            // Ninth bit read before the data word, which advances the buffer
            bus(0, 8'h08, 0, r);
            `CHK(r[7:0], {5'h1F, 1'b0, n9, n9})
            bus(0, 8'h00, 0, r);
            `CHK(r[8:0], {n9, b})
            // Odd passes clear by interrupt entry, even ones by writing one
            if (i[0]) begin
                ack <= 1'b1;
                @(posedge sys_clk);
                ack <= 1'b0;
            end else begin
                bus(1, 8'h04, 32'h40, r);
            end
            bus(0, 8'h04, 0, r);
            `CHK(r[7:6], 2'b00)
            `CHK(rxIrq, 1'b0)
            `CHK(txdIrq, 1'b0)
        end
        // Frame left unread, then both directions disabled
        rn.send({1'b1, seed[7:0]});
        bus(0, 8'h04, 0, r);
        `CHK(r[7], 1'b1)
        bus(1, 8'h08, 0, r);
        gpio <= 1'b0;
        repeat (3) @(posedge sys_clk);
        `CHK(txOwn, 1'b0)
        `CHK(rxOwn, 1'b0)
        `CHK(txPin, 1'b0)
        bus(0, 8'h04, 0, r);
        `CHK(r[7], 1'b0)
        finish_test();
    end
endmodule : testbench
`default_nettype wire
